// >>> src/led_pkg.sv
// shared constants for both ends of the led driver serial link
package led_pkg;
   // ************************************************************
   // geometry
   // ************************************************************
   localparam int NUM_CH   = 16;
   localparam int GS_W     = 12;
   localparam int SR_W     = 192;
   localparam int TRIM_W   = 8;
   localparam int TRIM6_W  = 6;
   localparam int LVL_W    = 16;
   localparam int NSYNC    = 7;
   localparam logic [7:0] GS_LEN    = 8'hC0;
   localparam logic [7:0] TRIM6_LEN = 8'h60;
   localparam logic [7:0] TRIM8_LEN = 8'h88;
   // ************************************************************
   // field positions
   // ************************************************************
   localparam int TRIM8_LSB    = 8;
   localparam int SID_TEMP_BIT = 16;
   localparam int SID_TRIM_LSB = 24;
   // ************************************************************
   // current scaling: percent figures in units of 0.01 percent, plus the 6-bit trim and global code maxima
   // ************************************************************
   localparam int PCT_FULL    = 10000;
   localparam int PCT_HI_BASE = 10027;
   localparam int PCT_STEP    = 27;
   localparam int TRIM6_MAX   = 63;
   localparam int GLOBAL_MAX  = 255;
   // ************************************************************
   // reset values and grayscale counter top
   // ************************************************************
   localparam logic [6:0]  SYNC_RST   = 7'h20;
   localparam logic [11:0] GS_CNT_TOP = 12'hFFF;
   // ************************************************************
   // timing
   // ************************************************************
   localparam int CORE_CLK_NS     = 20;
   localparam int STAGGER_NS      = 2;
   localparam int STAGGER_MAX_NS  = 30;
   localparam int STAGGER_CYC     = (STAGGER_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
   localparam int SHORT_BLANK_NS  = 30;
   localparam int SHORT_BLANK_CYC = (SHORT_BLANK_NS / CORE_CLK_NS < 1) ? 1
                                    : SHORT_BLANK_NS / CORE_CLK_NS;
   localparam logic [2:0] SCLK_HALF_CYC = 3'h4;
   localparam logic [2:0] STROBE_CYC    = 3'h4;
   localparam logic [2:0] SETUP_CYC     = 3'h4;
   localparam logic [2:0] GSCLK_HALF_CYC = 3'h4;
endpackage : led_pkg

// >>> src/led_link_if.sv
// serial link between the led controller and the led driver
`timescale 1ns/1ns
interface led_link_if;
   logic sclk;
   logic sdin;
   logic latch_strobe;
   logic mode_select;
   logic resolution_select;
   logic output_blank;
   logic gsclk;
   logic sdout;
   logic err_oe;
   wire  err_n;

   // open-drain fault line, pulled up when nobody drives it
   assign err_n = ~err_oe;

   modport ctl (
      output sclk, sdin, latch_strobe, mode_select, resolution_select,
      output output_blank, gsclk,
      input  sdout, err_n
   );
   modport dev (
      input  sclk, sdin, latch_strobe, mode_select, resolution_select,
      input  output_blank, gsclk,
      output sdout, err_oe
   );
endinterface : led_link_if

// >>> src/led_dev.sv
// device end: shift chain, latches, grayscale pwm, stagger and channel levels
`timescale 1ns/1ns
module led_dev (
   // clock and reset
   input  wire logic                                      i_core_clk,
   input  wire logic                                      i_rst_b,
   // link to controller
   led_link_if.dev                                        link,
   // sense inputs from the output stage
   input  wire logic [led_pkg::NUM_CH-1:0]                i_open_led_flag,
   input  wire logic                                      i_overtemp_flag,
   // channel drive
   output logic      [led_pkg::NUM_CH-1:0]                o_sink_channel,
   output logic      [led_pkg::NUM_CH*led_pkg::LVL_W-1:0] o_ch_level
);
   localparam int NCH = led_pkg::NUM_CH;
   localparam int DW  = (NCH - 1) * led_pkg::STAGGER_CYC;

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic [led_pkg::NSYNC-1:0] pin_meta_q;
   logic [led_pkg::NSYNC-1:0] pin_sync_q;
   logic [led_pkg::NSYNC-1:0] pin_prev_q;
   logic [NCH:0]              sense_meta_q;
   logic [NCH:0]              sense_sync_q;
   wire  [led_pkg::NSYNC-1:0] pins = {link.gsclk, link.output_blank, link.resolution_select,
                                      link.mode_select, link.latch_strobe, link.sdin,
                                      link.sclk};

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         pin_meta_q   <= led_pkg::SYNC_RST;
         pin_sync_q   <= led_pkg::SYNC_RST;
         pin_prev_q   <= led_pkg::SYNC_RST;
         sense_meta_q <= '0;
         sense_sync_q <= '0;
      end else begin
         pin_meta_q   <= pins;
         pin_sync_q   <= pin_meta_q;
         pin_prev_q   <= pin_sync_q;
         sense_meta_q <= {i_overtemp_flag, i_open_led_flag};
         sense_sync_q <= sense_meta_q;
      end
   end

   wire sclk_s      = pin_sync_q[0];
   wire sdin_s      = pin_sync_q[1];
   wire strobe_s    = pin_sync_q[2];
   wire mode_s      = pin_sync_q[3];
   wire res_s       = pin_sync_q[4];
   wire blank_s     = pin_sync_q[5];
   wire gsclk_s     = pin_sync_q[6];
   wire sclk_rise   = sclk_s & ~pin_prev_q[0];
   wire strobe_fall = ~strobe_s & pin_prev_q[2];
   wire gsclk_rise  = gsclk_s & ~pin_prev_q[6];
   wire blank_rise  = blank_s & ~pin_prev_q[5];
   wire [NCH-1:0] open_s = sense_sync_q[NCH-1:0];
   wire           hot_s  = sense_sync_q[NCH];

   // ************************************************************
   // input shift register and status readback
   // ************************************************************
   logic [led_pkg::SR_W-1:0] sr_q;
   logic [led_pkg::SR_W-1:0] sr_d;
   logic [led_pkg::SR_W-1:0] status_w;
   logic [7:0]               trim_q [NCH];
   logic [11:0]              gs_q   [NCH];
   logic [7:0]               global_q;

   wire [7:0] sr_len = !mode_s ? led_pkg::GS_LEN
                     : (res_s ? led_pkg::TRIM6_LEN : led_pkg::TRIM8_LEN);
   wire [7:0] sr_top = sr_len - 8'h01;

   always_comb begin
      status_w = '0;
      status_w[NCH-1:0] = open_s;
      status_w[led_pkg::SID_TEMP_BIT] = hot_s;
      for (int n = 0; n < NCH; n++) begin
         status_w[led_pkg::SID_TRIM_LSB + n*led_pkg::TRIM6_W +: led_pkg::TRIM6_W] =
            trim_q[n][led_pkg::TRIM6_W-1:0];
      end
   end

   always_comb begin
      sr_d = sr_q;
      if (strobe_fall && !mode_s) begin
         sr_d = status_w;
      // shift in, held while strobe high
      end else if (sclk_rise && !strobe_s) begin
         sr_d = {sr_q[led_pkg::SR_W-2:0], sdin_s};
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         sr_q       <= '0;
         link.sdout <= 1'b0;
      end else begin
         sr_q       <= sr_d;
         link.sdout <= sr_d[sr_top];
      end
   end

   // ************************************************************
   // level latches
   // ************************************************************
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         global_q <= '0;
         for (int n = 0; n < NCH; n++) begin
            gs_q[n]   <= '0;
            trim_q[n] <= '0;
         end
      end else if (strobe_s) begin
         for (int n = 0; n < NCH; n++) begin
            if (!mode_s) begin
               gs_q[n] <= sr_q[n*led_pkg::GS_W +: led_pkg::GS_W];
            // channel 15 sits at the top
            end else if (res_s) begin
               trim_q[n] <= {2'h0, sr_q[n*led_pkg::TRIM6_W +: led_pkg::TRIM6_W]};
            end else begin
               trim_q[n] <= sr_q[led_pkg::TRIM8_LSB + n*led_pkg::TRIM_W +: led_pkg::TRIM_W];
            end
         end
         if (mode_s && !res_s) begin
            global_q <= sr_q[led_pkg::TRIM_W-1:0];
         end
      end
   end

   // ************************************************************
   // grayscale counter and short blank pulse
   // ************************************************************
   logic [11:0] gs_cnt_q;
   logic [2:0]  low_cnt_q;
   logic [2:0]  short_left_q;

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         gs_cnt_q     <= '0;
         low_cnt_q    <= '0;
         short_left_q <= '0;
      end else begin
         if (blank_s) begin
            gs_cnt_q <= '0;
         end else if (gsclk_rise && gs_cnt_q != led_pkg::GS_CNT_TOP) begin
            gs_cnt_q <= gs_cnt_q + 12'h001;
         end
         if (blank_s) begin
            low_cnt_q <= '0;
         end else if (low_cnt_q != 3'h7) begin
            low_cnt_q <= low_cnt_q + 3'h1;
         end
         // short low window replayed after edge
         if (blank_rise && low_cnt_q <= 3'(led_pkg::SHORT_BLANK_CYC)) begin
            short_left_q <= low_cnt_q;
         end else if (short_left_q != 3'h0) begin
            short_left_q <= short_left_q - 3'h1;
         end
      end
   end

   // ************************************************************
   // channel compare, stagger and levels
   // ************************************************************
   logic [NCH-1:0]             raw_on;
   logic [NCH-1:0]             sink_d;
   logic [DW-1:0]              dly_q [NCH];
   logic [NCH*led_pkg::LVL_W-1:0] lvl_d;

   wire run_w = !blank_s && gs_cnt_q != 12'h000 && gs_cnt_q != led_pkg::GS_CNT_TOP;

   for (genvar n = 0; n < NCH; n++) begin : g_ch
      wire gs_nz = gs_q[n] != 12'h000;
      assign raw_on[n] = (run_w && gs_cnt_q <= gs_q[n]) || (short_left_q != 3'h0 && gs_nz);
      if (n == 0) begin : g_first
         assign sink_d[n] = raw_on[n];
      end else begin : g_rest
         assign sink_d[n] = dly_q[n][n*led_pkg::STAGGER_CYC-1];
      end

      wire [6:0]  step  = trim_q[n][6:0];
      // steps of 0.27 percent around full
      wire [31:0] mag8  = trim_q[n][7] ? 32'(led_pkg::PCT_HI_BASE + led_pkg::PCT_STEP * step)
                                       : 32'(led_pkg::PCT_FULL - led_pkg::PCT_STEP * step);
      wire [31:0] lvl6  = 32'(trim_q[n][5:0]) * 32'(led_pkg::PCT_FULL) / 32'(led_pkg::TRIM6_MAX);
      wire [31:0] lvl8  = mag8 * 32'(global_q) / 32'(led_pkg::GLOBAL_MAX);
      assign lvl_d[n*led_pkg::LVL_W +: led_pkg::LVL_W] = res_s ? lvl6[led_pkg::LVL_W-1:0]
                                                               : lvl8[led_pkg::LVL_W-1:0];
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         for (int n = 0; n < NCH; n++) begin
            dly_q[n] <= '0;
         end
         o_sink_channel <= '0;
         o_ch_level     <= '0;
         link.err_oe    <= 1'b0;
      end else begin
         for (int n = 0; n < NCH; n++) begin
            dly_q[n] <= {dly_q[n][DW-2:0], raw_on[n]};
         end
         o_sink_channel <= sink_d;
         o_ch_level     <= lvl_d;
         // open-led masked while blanked
         link.err_oe    <= hot_s | (|open_s & ~blank_s);
      end
   end
endmodule : led_dev

// >>> src/led_ctl.sv
// controller end: drives the serial chain, strobe, blank and grayscale clock
`timescale 1ns/1ns
module led_ctl (
   // clock and reset
   input  wire logic                     i_core_clk,
   input  wire logic                     i_rst_b,
   // link to device
   led_link_if.ctl                       link,
   // user requests
   input  wire logic                     i_start,
   input  wire logic                     i_read_status,
   input  wire logic                     i_mode_select,
   input  wire logic                     i_resolution_select,
   input  wire logic [led_pkg::SR_W-1:0] i_data,
   input  wire logic                     i_blank,
   input  wire logic                     i_gs_run,
   // user answers
   output logic                          o_busy,
   output logic                          o_done,
   output logic                          o_refused,
   output logic                          o_fault,
   output logic      [led_pkg::SR_W-1:0] o_rx_data
);
   typedef enum {S_IDLE, S_SETUP, S_LOW, S_HIGH, S_STROBE, S_HOLD} state_t;

   state_t                   st_q;
   logic [2:0]               tmr_q;
   logic [7:0]               bit_q;
   logic                     rd_q;
   logic                     gs_ok_q;
   logic                     trim_ok_q;
   logic [led_pkg::SR_W-1:0] tx_q;
   logic [1:0]               meta_q;
   logic [1:0]               sync_q;
   logic [2:0]               gdiv_q;

   wire [7:0] len_w = !i_mode_select ? led_pkg::GS_LEN
                    : (i_resolution_select ? led_pkg::TRIM6_LEN : led_pkg::TRIM8_LEN);
   wire [7:0] pad_w = led_pkg::GS_LEN - len_w;
   wire       t0    = tmr_q == 3'h0;
   // no trim before first grayscale load
   wire       deny  = i_start && !i_read_status && i_mode_select && !gs_ok_q;

   // ************************************************************
   // sampling of device outputs
   // ************************************************************
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         meta_q <= 2'h2;
         sync_q <= 2'h2;
      end else begin
         meta_q <= {link.err_n, link.sdout};
         sync_q <= meta_q;
      end
   end

   // ************************************************************
   // transfer sequencer
   // ************************************************************
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         st_q <= S_IDLE;
         tmr_q <= '0;
         bit_q <= '0;
         rd_q <= 1'b0;
         gs_ok_q <= 1'b0;
         trim_ok_q <= 1'b0;
         tx_q <= '0;
         o_rx_data <= '0;
         o_done <= 1'b0;
         o_refused <= 1'b0;
         link.sclk <= 1'b0;
         link.sdin <= 1'b0;
         link.latch_strobe <= 1'b0;
         link.mode_select <= 1'b0;
         link.resolution_select <= 1'b0;
      end else begin
         o_done <= 1'b0;
         o_refused <= 1'b0;
         tmr_q <= t0 ? 3'h0 : tmr_q - 3'h1;
         case (st_q)
            S_IDLE: begin
               o_refused <= deny;
               if (i_start && !deny) begin
                  rd_q <= i_read_status;
                  tx_q <= i_read_status ? '0 : i_data << pad_w;
                  bit_q <= i_read_status ? led_pkg::GS_LEN : len_w;
                  // mode pins move only with strobe low
                  link.mode_select <= i_read_status ? 1'b0 : i_mode_select;
                  link.resolution_select <= i_resolution_select;
                  tmr_q <= led_pkg::SETUP_CYC - 3'h1;
                  st_q <= S_SETUP;
               end
            end
            S_SETUP: begin
               if (t0) begin
                  tmr_q <= led_pkg::SCLK_HALF_CYC - 3'h1;
                  st_q <= rd_q ? S_STROBE : S_LOW;
                  if (rd_q) begin
                     tmr_q <= led_pkg::STROBE_CYC - 3'h1;
                  end
               end
            end
            S_LOW: begin
               link.sdin <= tx_q[led_pkg::SR_W-1];
               if (t0) begin
                  o_rx_data <= {o_rx_data[led_pkg::SR_W-2:0], sync_q[0]};
                  link.sclk <= 1'b1;
                  tmr_q <= led_pkg::SCLK_HALF_CYC - 3'h1;
                  st_q <= S_HIGH;
               end
            end
            S_HIGH: begin
               if (t0) begin
                  link.sclk <= 1'b0;
                  tx_q <= {tx_q[led_pkg::SR_W-2:0], 1'b0};
                  bit_q <= bit_q - 8'h01;
                  tmr_q <= bit_q == 8'h01 ? led_pkg::STROBE_CYC - 3'h1
                                          : led_pkg::SCLK_HALF_CYC - 3'h1;
                  st_q <= bit_q != 8'h01 ? S_LOW : (rd_q ? S_IDLE : S_STROBE);
                  o_done <= bit_q == 8'h01 && rd_q;
               end
            end
            S_STROBE: begin
               // strobe with clock and data parked
               link.latch_strobe <= !t0;
               if (t0) begin
                  tmr_q <= led_pkg::SETUP_CYC - 3'h1;
                  st_q <= S_HOLD;
               end
            end
            S_HOLD: begin
               if (t0) begin
                  tmr_q <= led_pkg::SCLK_HALF_CYC - 3'h1;
                  st_q <= rd_q ? S_LOW : S_IDLE;
                  o_done <= !rd_q;
                  gs_ok_q <= gs_ok_q | (!rd_q && !link.mode_select);
                  trim_ok_q <= trim_ok_q | (!rd_q && link.mode_select);
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end

   // ************************************************************
   // blank and grayscale clock
   // ************************************************************
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         gdiv_q <= '0;
         link.gsclk <= 1'b0;
         link.output_blank <= 1'b1;
         o_busy <= 1'b0;
         o_fault <= 1'b0;
      end else begin
         gdiv_q <= (gdiv_q == led_pkg::GSCLK_HALF_CYC - 3'h1) ? 3'h0 : gdiv_q + 3'h1;
         if (gdiv_q == led_pkg::GSCLK_HALF_CYC - 3'h1) begin
            link.gsclk <= i_gs_run & ~link.gsclk;
         end
         link.output_blank <= i_blank | ~(gs_ok_q & trim_ok_q);
         o_busy <= st_q != S_IDLE || (i_start && !deny);
         o_fault <= ~sync_q[1];
      end
   end
endmodule : led_ctl

// >>> verification/led_link_assertions.sv
// protocol checker for the serial link between controller and driver
`timescale 1ns/1ns
module led_link_assertions (
   // clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_rst_b,
   // link signals
   input  wire logic sclk,
   input  wire logic sdin,
   input  wire logic latch_strobe,
   input  wire logic mode_select,
   input  wire logic output_blank,
   input  wire logic gsclk
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);
   logic gs_seen_q;
   logic tr_seen_q;
   // ************************************************************
   // latch history
   // ************************************************************
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         gs_seen_q <= 1'b0;
         tr_seen_q <= 1'b0;
      end else if ($fell(latch_strobe)) begin
         gs_seen_q <= gs_seen_q | ~mode_select;
         tr_seen_q <= tr_seen_q | mode_select;
      end
   end
   // ************************************************************
   // properties
   // ************************************************************
   mode_quiet_a: assert property (
      $changed(mode_select) |-> !latch_strobe && !$past(latch_strobe))
      else $error("mode changed around a strobe");
   strobe_still_a: assert property (
      latch_strobe && $past(latch_strobe) |-> $stable(sclk) && $stable(sdin))
      else $error("shift clock or data moved under strobe");
   strobe_width_a: assert property (
      $rose(latch_strobe) |-> latch_strobe [*3] ##1 !latch_strobe)
      else $error("strobe pulse width wrong");
   sclk_high_a: assert property (
      $rose(sclk) |-> sclk [*4] ##1 !sclk)
      else $error("shift clock high phase wrong");
   sclk_low_a: assert property (
      $fell(sclk) |-> !sclk [*4])
      else $error("shift clock low phase too short");
   sdin_hold_a: assert property (
      sclk |-> $stable(sdin))
      else $error("data moved while shift clock high");
   gsclk_half_a: assert property (
      $rose(gsclk) |-> gsclk [*4] ##1 !gsclk [*4])
      else $error("grayscale clock period wrong");
   trim_order_a: assert property (
      $rose(latch_strobe) && mode_select |-> gs_seen_q)
      else $error("trim latched before grayscale");
   blank_hold_a: assert property (
      !(gs_seen_q && tr_seen_q) |-> output_blank)
      else $error("outputs unblanked before both latches loaded");
endmodule : led_link_assertions

// >>> verification/led_driver_dot_correction_config_test.sv
// self-checking bench: controller and driver joined over the serial link
`timescale 1ns/1ns
module led_driver_dot_correction_config_test;
   typedef struct packed {
      logic         refused;
      logic [191:0] rx;
      logic [191:0] mask;
   } exp_t;
   logic                                      i_core_clk, i_rst_b, i_start, i_read_status;
   logic                                      i_mode_select, i_resolution_select;
   logic                                      i_blank, i_gs_run, i_overtemp_flag;
   logic                                      o_busy, o_done, o_refused, o_fault;
   logic [led_pkg::SR_W-1:0]                  i_data, o_rx_data, d;
   logic [led_pkg::NUM_CH-1:0]                i_open_led_flag, o_sink_channel, sink_or;
   logic [led_pkg::NUM_CH*led_pkg::LVL_W-1:0] o_ch_level;
   logic [7:0]                                b;
   int                                        error_cnt, check_count, seed;
   exp_t                                      exp_q[$];
   exp_t                                      ex, got_e;

   led_link_if lnk ();
   led_ctl i_led_ctl (.i_core_clk, .i_rst_b, .link(lnk), .i_start, .i_read_status,
      .i_mode_select, .i_resolution_select, .i_data, .i_blank, .i_gs_run,
      .o_busy, .o_done, .o_refused, .o_fault, .o_rx_data);
   led_dev i_led_dev (.i_core_clk, .i_rst_b, .link(lnk), .i_open_led_flag,
      .i_overtemp_flag, .o_sink_channel, .o_ch_level);
   led_link_assertions i_led_link_assertions (.i_core_clk, .i_rst_b, .sclk(lnk.sclk),
      .sdin(lnk.sdin), .latch_strobe(lnk.latch_strobe), .mode_select(lnk.mode_select),
      .output_blank(lnk.output_blank), .gsclk(lnk.gsclk));

   // ************************************************************
   // checking
   // ************************************************************
   task automatic note(input bit ok, input logic [192:0] got, input logic [192:0] exp);
      check_count++;
      if (!ok) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : note
   task automatic cmp_rx(input logic [192:0] got, input logic [192:0] exp);
      note(got === exp, got, exp);
   endtask : cmp_rx
   task automatic cmp_lvl(input logic [15:0] got, input logic [15:0] exp);
      note(got === exp, 193'(got), 193'(exp));
   endtask : cmp_lvl
   task automatic cmp_sink(input logic [15:0] got, input logic [15:0] exp);
      note(got === exp, 193'(got), 193'(exp));
   endtask : cmp_sink
   task automatic cmp_flag(input logic got, input logic exp);
      note(got === exp, 193'(got), 193'(exp));
   endtask : cmp_flag
   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_sim
   always @(negedge i_core_clk) begin
      if (o_done === 1'b1 || o_refused === 1'b1) begin
         got_e = exp_q.pop_front();
         cmp_rx({o_refused, o_rx_data & got_e.mask}, {got_e.refused, got_e.rx});
      end
   end

   // ************************************************************
   // stimulus
   // ************************************************************
   function automatic logic [191:0] rnd();
      logic [191:0] r;
      for (int k = 0; k < 6; k++) r = {r[159:0], 32'($random(seed))};
      return r;
   endfunction : rnd
   task automatic op(input logic rd, md, rs, input logic [191:0] data, input exp_t e);
      int k;
      exp_q.push_back(e);
      @(negedge i_core_clk);
      {i_read_status, i_mode_select, i_resolution_select, i_data} <= {rd, md, rs, data};
      i_start <= 1'b1;
      @(negedge i_core_clk);
      i_start <= 1'b0;
      cmp_flag(o_busy, ~e.refused);
      for (k = 0; k < 3000 && !(o_done === 1'b1 || o_refused === 1'b1); k++)
         @(negedge i_core_clk);
      // no answer within the limit counts as a mismatch
      if (k == 3000) begin
         error_cnt++;
      end
      @(negedge i_core_clk);
   endtask : op
   task automatic blank_wait(input logic bl, input int n);
      i_blank <= bl;
      repeat (n) @(negedge i_core_clk);
   endtask : blank_wait
   initial begin
      i_core_clk = 1'b0;
      forever #10 i_core_clk = ~i_core_clk;
   end
   initial begin
      #400000;
      error_cnt++;
      end_sim();
   end
   initial begin
      seed = 32'h5b4d_c2e3;
      {i_rst_b, i_start, i_read_status, i_mode_select, i_resolution_select} = '0;
      {i_blank, i_gs_run, i_data} = {2'b11, 192'h0};
      i_open_led_flag = 16'($random(seed));
      i_overtemp_flag = 1'($random(seed));
      repeat (20) @(negedge i_core_clk);
      i_rst_b = 1'b1;
      op(1'b0, 1'b1, 1'b1, rnd(), '{1'b1, '0, '0});
      d = '0;
      for (int n = 1; n < 16; n += 2) d[12*n+:12] = 12'h028;
      op(1'b0, 1'b0, 1'b0, d, '{1'b0, '0, '0});
      d = rnd();
      op(1'b0, 1'b1, 1'b1, d, '{1'b0, '0, '0});
      for (int n = 0; n < 16; n++)
         cmp_lvl(o_ch_level[16*n+:16], 16'(int'(d[6*n+:6]) * led_pkg::PCT_FULL /
            led_pkg::TRIM6_MAX));
      blank_wait(1'b0, 200);
      cmp_sink(o_sink_channel, 16'hAAAA);
      blank_wait(1'b0, 400);
      cmp_sink(o_sink_channel, 16'h0000);
      blank_wait(1'b1, 40);
      blank_wait(1'b0, 200);
      cmp_sink(o_sink_channel, 16'hAAAA);
      cmp_flag(o_fault, i_overtemp_flag | (|i_open_led_flag));
      blank_wait(1'b1, 40);
      cmp_sink(o_sink_channel, 16'h0000);
      cmp_flag(o_fault, i_overtemp_flag);
      // one-cycle blank low: lit channels must still pulse afterwards
      i_blank <= 1'b0;
      @(negedge i_core_clk);
      i_blank <= 1'b1;
      sink_or = '0;
      repeat (40) begin
         @(negedge i_core_clk);
         sink_or = sink_or | o_sink_channel;
      end
      cmp_sink(sink_or, 16'hAAAA);
      blank_wait(1'b0, 1);
      d = rnd();
      op(1'b0, 1'b1, 1'b0, d, '{1'b0, '0, '0});
      for (int n = 0; n < 16; n++) begin
         b = d[led_pkg::TRIM8_LSB+8*n+:8];
         cmp_lvl(o_ch_level[16*n+:16], 16'((b[7] ? led_pkg::PCT_HI_BASE + led_pkg::PCT_STEP * b[6:0]
            : led_pkg::PCT_FULL - led_pkg::PCT_STEP * b[6:0]) * d[7:0] /
            led_pkg::GLOBAL_MAX));
      end
      blank_wait(1'b1, 40);
      ex = '{1'b0, '0, '0};
      ex.rx[16:0] = {i_overtemp_flag, i_open_led_flag};
      ex.mask[16:0] = '1;
      for (int n = 0; n < 16; n++) begin
         ex.rx[24+6*n+:6] = d[8+8*n+:6];
         ex.mask[24+6*n+:6] = '1;
      end
      op(1'b1, 1'b0, 1'b0, '0, ex);
      end_sim();
   end
endmodule : led_driver_dot_correction_config_test
